// *** src/tla_cfg.svh ***
// Constants for the temperature limit and alert block
`ifndef TLA_CFG_SVH
`define TLA_CFG_SVH
`define TLA_RES_W         14
`define TLA_WORD_W        16
`define TLA_JUST_PAD      2
`define TLA_MODE_LATCH    1'b0
`define TLA_MODE_THERM    1'b1
`define TLA_POL_BIT_A     7
`define TLA_POL_BIT_B     3
`define TLA_HI_DISABLE    16'h7FFC
`define TLA_LO_DISABLE    16'h8000
`define TLA_RESULT_RST    16'h0000
`define TLA_BAUD_MIN_HZ   4800
`define TLA_BAUD_MAX_HZ   115400
`define TLA_CLK_HZ        100000000
`define TLA_BIT_CYC_MAX   (`TLA_CLK_HZ / `TLA_BAUD_MIN_HZ)
`define TLA_BIT_CYC_MIN   (`TLA_CLK_HZ / `TLA_BAUD_MAX_HZ)
`endif

// *** src/tla_pkg.sv ***
// Types shared by the temperature limit and alert block
package tla_pkg;
  typedef struct packed {
    logic [15:0] high_limit;
    logic [15:0] low_limit;
  } tla_limits_t;
  typedef struct packed {
    logic over_high_flag;
    logic under_low_flag;
    logic alert_active;
  } tla_chan_status_t;
  typedef struct packed {
    logic comparator_mode_sel;
    logic output_polarity_n;
  } tla_chan_cfg_t;
endpackage

// *** src/tla_format.sv ***
// Left-justifies a raw 14-bit twos-complement conversion into a result word
`timescale 1ns/1ps
`include "tla_cfg.svh"
module tla_format #(
  parameter int RES_W = `TLA_RES_W
) (
  // Raw conversion
  input  wire logic [RES_W-1:0] raw_in,
  // Formatted word
  output logic      [15:0]      word_out
);
  // Low pad bits are zero so one LSB is 0.015625 C after shifting
  assign word_out = {raw_in, {(16 - RES_W){1'b0}}};
endmodule

// *** src/tla_channel.sv ***
// One alert channel: window compare, latched or therm mode, polarity
`timescale 1ns/1ps
`include "tla_cfg.svh"
module tla_channel
  import tla_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Conversion result and this channel's limits and settings
  input  wire logic             conv_done_in,
  input  wire logic [15:0]      result_in,
  input  tla_pkg::tla_limits_t   limits_in,
  input  tla_pkg::tla_chan_cfg_t cfg_in,
  // Host side effects
  input  wire logic             cfg_read_in,
  input  wire logic             alert_clear_in,
  // Flags and pin level
  output tla_pkg::tla_chan_status_t status_out,
  output logic                  pin_out
);
  import tla_pkg::*;

  logic hi_q, hi_d, lo_q, lo_d, al_q, al_d;
  logic above, below;

  // Signed compare so negative codes order correctly
  assign above = $signed(result_in) > $signed(limits_in.high_limit);
  assign below = $signed(result_in) < $signed(limits_in.low_limit);

  // Next state; set wins over a same-cycle clear
  always_comb begin
    hi_d = hi_q;
    lo_d = lo_q;
    al_d = al_q;
    if (cfg_in.comparator_mode_sel == `TLA_MODE_THERM) begin
      lo_d = 1'b0;
      // Reads and clear commands do nothing here
      if (conv_done_in) begin
        if (above) begin
          hi_d = 1'b1;
          al_d = 1'b1;
        end else if (below) begin
          hi_d = 1'b0;
          al_d = 1'b0;
        end
      end
    end else begin
      if (cfg_read_in) begin
        hi_d = 1'b0;
        lo_d = 1'b0;
        al_d = 1'b0;
      end
      if (alert_clear_in) begin
        al_d = 1'b0;
      end
      if (conv_done_in && above) begin
        hi_d = 1'b1;
        al_d = 1'b1;
      end
      if (conv_done_in && below) begin
        lo_d = 1'b1;
        al_d = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
      al_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      al_q <= al_d;
    end
  end

  assign status_out = '{over_high_flag: hi_q, under_low_flag: lo_q, alert_active: al_q};
  // Idle level is the inverse of polarity; disabled limits make this a GPO
  assign pin_out = al_q ? cfg_in.output_polarity_n : ~cfg_in.output_polarity_n;

  AST_SET_ON_HIGH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    conv_done_in && above |=> hi_q && al_q)
    else $error("high event did not set flag and alert");
  AST_THERM_LOW_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_in.comparator_mode_sel && $past(cfg_in.comparator_mode_sel) |-> !lo_q)
    else $error("low flag active in therm mode");
  AST_THERM_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_in.comparator_mode_sel && !conv_done_in |=> $stable(al_q))
    else $error("therm alert changed without conversion");
  AST_LATCH_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !cfg_in.comparator_mode_sel && al_q && !cfg_read_in && !alert_clear_in |=> al_q)
    else $error("latched alert dropped without clear");
  AST_READ_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !cfg_in.comparator_mode_sel && cfg_read_in && !conv_done_in |=> !hi_q && !lo_q && !al_q)
    else $error("config read did not clear latched state");
  AST_THERM_RELEASE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_in.comparator_mode_sel && conv_done_in && !above && below |=> !al_q && !hi_q)
    else $error("therm alert not released below low limit");
  // An over-limit result must leave the pin at the level its polarity bit names
  AST_POLARITY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    conv_done_in && above |=> pin_out == cfg_in.output_polarity_n)
    else $error("alert pin not at active level after high event");
endmodule

// *** src/tla_top.sv ***
// Temperature result store and two-channel limit alert logic
`timescale 1ns/1ps
`include "tla_cfg.svh"
module tla_top
  import tla_pkg::*;
#(
  parameter int RES_W = `TLA_RES_W
) (
  // Clock and reset
  input  wire logic             CLK_SYS_IN,
  input  wire logic             RST_N_IN,
  // Conversion result from the converter
  input  wire logic             CONV_DONE_IN,
  input  wire logic [RES_W-1:0] CONV_RAW_IN,
  // Nonvolatile limit defaults, one struct per channel
  input  tla_limits_t           NV_LIMITS_A_IN,
  input  tla_limits_t           NV_LIMITS_B_IN,
  // Host limit writes from the bus logic
  input  wire logic             LIMIT_WR_A_IN,
  input  wire logic             LIMIT_WR_B_IN,
  input  tla_limits_t           LIMIT_WDATA_IN,
  // Configuration byte write and read strobes
  input  wire logic             CFG_WR_IN,
  input  wire logic [7:0]       CFG_WDATA_IN,
  input  wire logic             CFG_RD_IN,
  // Per-channel alert clear commands
  input  wire logic             ALERT_CLR_A_IN,
  input  wire logic             ALERT_CLR_B_IN,
  // Readback
  output logic      [15:0]      RESULT_OUT,
  output logic      [7:0]       RESULT_MSB_OUT,
  output logic      [7:0]       RESULT_LSB_OUT,
  output logic      [7:0]       CFG_RDATA_OUT,
  output tla_limits_t           LIMITS_A_OUT,
  output tla_limits_t           LIMITS_B_OUT,
  output tla_chan_status_t      STATUS_A_OUT,
  output tla_chan_status_t      STATUS_B_OUT,
  // Alert pins, open drain: enable low pulls the pin low
  output logic                  ALERT_OUT_A_OE_N_OUT,
  output logic                  ALERT_OUT_B_OE_N_OUT
);
  import tla_pkg::*;

  logic [15:0]  result_q, result_d, fmt_word;
  logic [7:0]   cfg_q, cfg_d;
  tla_limits_t  lim_a_q, lim_a_d, lim_b_q, lim_b_d;
  logic         nv_load_q, nv_load_d;
  tla_chan_cfg_t cfg_a, cfg_b;
  logic         pin_a, pin_b;

  tla_format #(.RES_W(RES_W)) u_fmt (
    .raw_in   (CONV_RAW_IN),
    .word_out (fmt_word)
  );

  // Next values; nonvolatile defaults are taken one cycle after reset release,
  // since an async reset may only load constants
  always_comb begin
    result_d  = result_q;
    cfg_d     = cfg_q;
    lim_a_d   = lim_a_q;
    lim_b_d   = lim_b_q;
    nv_load_d = 1'b0;
    if (CONV_DONE_IN) begin
      result_d = fmt_word;
    end
    if (CFG_WR_IN) begin
      cfg_d = CFG_WDATA_IN;
    end
    if (nv_load_q) begin
      lim_a_d = NV_LIMITS_A_IN;
      lim_b_d = NV_LIMITS_B_IN;
    end else begin
      if (LIMIT_WR_A_IN) begin
        lim_a_d = LIMIT_WDATA_IN;
      end
      if (LIMIT_WR_B_IN) begin
        lim_b_d = LIMIT_WDATA_IN;
      end
    end
  end

  // Registers; limits reset to the disabled pair until defaults arrive
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      result_q  <= `TLA_RESULT_RST;
      cfg_q     <= 8'h00;
      lim_a_q   <= '{high_limit: `TLA_HI_DISABLE, low_limit: `TLA_LO_DISABLE};
      lim_b_q   <= '{high_limit: `TLA_HI_DISABLE, low_limit: `TLA_LO_DISABLE};
      nv_load_q <= 1'b1;
    end else begin
      result_q  <= result_d;
      cfg_q     <= cfg_d;
      lim_a_q   <= lim_a_d;
      lim_b_q   <= lim_b_d;
      nv_load_q <= nv_load_d;
    end
  end

  // Mode bit sits just below each polarity bit
  assign cfg_a = '{comparator_mode_sel: cfg_q[`TLA_POL_BIT_A-1],
                   output_polarity_n:   cfg_q[`TLA_POL_BIT_A]};
  assign cfg_b = '{comparator_mode_sel: cfg_q[`TLA_POL_BIT_B-1],
                   output_polarity_n:   cfg_q[`TLA_POL_BIT_B]};

  tla_channel u_chan_a (
    .clk_in         (CLK_SYS_IN),
    .rst_n_in       (RST_N_IN),
    .conv_done_in   (CONV_DONE_IN),
    .result_in      (fmt_word),
    .limits_in      (lim_a_q),
    .cfg_in         (cfg_a),
    .cfg_read_in    (CFG_RD_IN),
    .alert_clear_in (ALERT_CLR_A_IN),
    .status_out     (STATUS_A_OUT),
    .pin_out        (pin_a)
  );

  tla_channel u_chan_b (
    .clk_in         (CLK_SYS_IN),
    .rst_n_in       (RST_N_IN),
    .conv_done_in   (CONV_DONE_IN),
    .result_in      (fmt_word),
    .limits_in      (lim_b_q),
    .cfg_in         (cfg_b),
    .cfg_read_in    (CFG_RD_IN),
    .alert_clear_in (ALERT_CLR_B_IN),
    .status_out     (STATUS_B_OUT),
    .pin_out        (pin_b)
  );

  // Outputs; pin high means released so the pullup shows it
  assign RESULT_OUT           = result_q;
  assign RESULT_MSB_OUT       = result_q[15:8];
  assign RESULT_LSB_OUT       = result_q[7:0];
  assign LIMITS_A_OUT         = lim_a_q;
  assign LIMITS_B_OUT         = lim_b_q;
  assign ALERT_OUT_A_OE_N_OUT = pin_a;
  assign ALERT_OUT_B_OE_N_OUT = pin_b;
  // Config readback carries flags in the spare low bits of each nibble
  assign CFG_RDATA_OUT = {cfg_q[7:6], STATUS_A_OUT.over_high_flag, STATUS_A_OUT.under_low_flag,
                          cfg_q[3:2], STATUS_B_OUT.over_high_flag, STATUS_B_OUT.under_low_flag};

  AST_RESULT_STORE: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    CONV_DONE_IN |=> result_q == {$past(CONV_RAW_IN), 2'b00})
    else $error("result not stored at conversion end");
  AST_NV_LOAD: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    nv_load_q |=> lim_a_q == $past(NV_LIMITS_A_IN) && lim_b_q == $past(NV_LIMITS_B_IN))
    else $error("limits not loaded from nonvolatile defaults");
  AST_LIMIT_WRITE: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    !nv_load_q && LIMIT_WR_B_IN |=> lim_b_q == $past(LIMIT_WDATA_IN))
    else $error("channel b limit write lost");
endmodule

// *** verif/tla_host_model.sv ***
// Host-side model that drives conversion, limit, configuration and clear strobes
`timescale 1ns/1ps
module tla_host_model
  import tla_pkg::*;
(
  // Clock
  input  wire logic   clk_in,
  // Requests toward the block
  output logic        conv_done_out,
  output logic [13:0] conv_raw_out,
  output logic        lim_wr_a_out,
  output logic        lim_wr_b_out,
  output tla_limits_t lim_wdata_out,
  output logic        cfg_wr_out,
  output logic [7:0]  cfg_wdata_out,
  output logic        cfg_rd_out,
  output logic        clr_a_out,
  output logic        clr_b_out
);
  // Everything idle at time zero
  initial begin
    {conv_done_out, lim_wr_a_out, lim_wr_b_out, cfg_wr_out, cfg_rd_out} = '0;
    {clr_a_out, clr_b_out, conv_raw_out, lim_wdata_out, cfg_wdata_out} = '0;
  end
  // One-cycle request: 0 conv, 1/2 limit A/B, 3 cfg write, 4 cfg read, 5/6 clear A/B
  task automatic send(input int kind, input logic [31:0] data);
    @(negedge clk_in);
    conv_raw_out  = data[13:0];
    lim_wdata_out = data;
    cfg_wdata_out = data[7:0];
    {conv_done_out, lim_wr_a_out, lim_wr_b_out} = {kind == 0, kind == 1, kind == 2};
    {cfg_wr_out, cfg_rd_out} = {kind == 3, kind == 4};
    {clr_a_out, clr_b_out}   = {kind == 5, kind == 6};
    @(negedge clk_in);
    {conv_done_out, lim_wr_a_out, lim_wr_b_out, cfg_wr_out, cfg_rd_out} = '0;
    {clr_a_out, clr_b_out} = '0;
    // Unqualified data flips so a design that samples late cannot pass by luck
    {conv_raw_out, lim_wdata_out, cfg_wdata_out} = ~{data[13:0], data, data[7:0]};
  endtask
endmodule

// *** verif/tla_top_tb_top.sv ***
// Self-checking bench for the temperature limit and alert block
`timescale 1ns/1ps
`include "tla_cfg.svh"
module tla_top_tb_top;
  import tla_pkg::*;
  logic             clk_sys, rst_n;
  tla_limits_t      nv_a, nv_b, lim_wdata, lim_a, lim_b;
  logic             conv_done, lim_wr_a, lim_wr_b, cfg_wr, cfg_rd, clr_a, clr_b;
  logic [13:0]      conv_raw;
  logic [7:0]       cfg_wdata, r_msb, r_lsb, cfg_rdata, cfg_m;
  logic [15:0]      result, res_m;
  tla_chan_status_t st_a, st_b;
  tla_chan_status_t st_m [2];
  tla_limits_t      lim_m [2];
  logic             oe_a, oe_b, pin_a, pin_b;
  logic [1:0]       modes;
  int               err_count = 0, samples_checked = 0, seed = 48;
  // Pulled-up open-drain pins: low only while the enable is low
  assign pin_a = oe_a ? 1'b1 : 1'b0;
  assign pin_b = oe_b ? 1'b1 : 1'b0;
  tla_host_model host (.clk_in(clk_sys), .conv_done_out(conv_done), .conv_raw_out(conv_raw),
    .lim_wr_a_out(lim_wr_a), .lim_wr_b_out(lim_wr_b), .lim_wdata_out(lim_wdata),
    .cfg_wr_out(cfg_wr), .cfg_wdata_out(cfg_wdata), .cfg_rd_out(cfg_rd),
    .clr_a_out(clr_a), .clr_b_out(clr_b));
  tla_top dut (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .CONV_DONE_IN(conv_done),
    .CONV_RAW_IN(conv_raw), .NV_LIMITS_A_IN(nv_a), .NV_LIMITS_B_IN(nv_b),
    .LIMIT_WR_A_IN(lim_wr_a), .LIMIT_WR_B_IN(lim_wr_b), .LIMIT_WDATA_IN(lim_wdata),
    .CFG_WR_IN(cfg_wr), .CFG_WDATA_IN(cfg_wdata), .CFG_RD_IN(cfg_rd),
    .ALERT_CLR_A_IN(clr_a), .ALERT_CLR_B_IN(clr_b), .RESULT_OUT(result),
    .RESULT_MSB_OUT(r_msb), .RESULT_LSB_OUT(r_lsb), .CFG_RDATA_OUT(cfg_rdata),
    .LIMITS_A_OUT(lim_a), .LIMITS_B_OUT(lim_b), .STATUS_A_OUT(st_a), .STATUS_B_OUT(st_b),
    .ALERT_OUT_A_OE_N_OUT(oe_a), .ALERT_OUT_B_OE_N_OUT(oe_b));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic mode(input int c);
    return c ? cfg_m[2] : cfg_m[6];
  endfunction
  function automatic logic pol(input int c);
    return c ? cfg_m[3] : cfg_m[7];
  endfunction
  // Keeps the low limit at or below the high limit so the window is well formed
  function automatic tla_limits_t rand_lim();
    logic [15:0] h;
    logic [15:0] l;
    h = 16'($random(seed)) & 16'hFFFC;
    l = 16'($random(seed)) & 16'hFFFC;
    if ($signed(l) > $signed(h)) return {l, h};
    return {h, l};
  endfunction
  function automatic logic [7:0] cfg_byte(input logic [7:0] r);
    return {r[7], modes[1], 2'b00, r[3], modes[0], 2'b00};
  endfunction
  // Expected channel state after one finished conversion
  function automatic tla_chan_status_t conv_step(input tla_chan_status_t s,
      input logic [15:0] w, input tla_limits_t l, input logic therm);
    logic hi;
    logic lo;
    hi = $signed(w) > $signed(l.high_limit);
    lo = $signed(w) < $signed(l.low_limit);
    if (therm) begin
      if (hi) s = 3'b101;
      else if (lo) s = 3'b000;
      s.under_low_flag = 1'b0;
    end else begin
      if (hi | lo) s.alert_active = 1'b1;
      if (hi) s.over_high_flag = 1'b1;
      if (lo) s.under_low_flag = 1'b1;
    end
    return s;
  endfunction
  task automatic chk_val(input string what, input logic [31:0] exp_v, input logic [31:0] got_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp_v, got_v);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp_v, input logic got_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp_v, got_v);
    end
  endtask
  task automatic check_all();
    logic [7:0] cfg_x;
    // Flags take the place of bits 5:4 and 1:0 in the readback
    cfg_x = {cfg_m[7:6], st_m[0][2:1], cfg_m[3:2], st_m[1][2:1]};
    chk_val("result", res_m, result);
    chk_val("result_bytes", res_m, {r_msb, r_lsb});
    chk_val("cfg_rdata", cfg_x, cfg_rdata);
    chk_val("limits_a", lim_m[0], lim_a);
    chk_val("limits_b", lim_m[1], lim_b);
    chk_val("status_a", st_m[0], st_a);
    chk_val("status_b", st_m[1], st_b);
    chk_pin("pin_a", st_m[0].alert_active ? pol(0) : ~pol(0), pin_a);
    chk_pin("pin_b", st_m[1].alert_active ? pol(1) : ~pol(1), pin_b);
  endtask
  task automatic op(input int kind, input logic [31:0] d);
    host.send(kind, d);
    case (kind)
      0: begin
        res_m = {d[13:0], 2'b00};
        for (int c = 0; c < 2; c++) begin
          st_m[c] = conv_step(st_m[c], res_m, lim_m[c], mode(c));
        end
      end
      1, 2: lim_m[kind-1] = d;
      3: cfg_m = d[7:0];
      4: for (int c = 0; c < 2; c++) if (!mode(c)) st_m[c] = '0;
      default: if (!mode(kind-5)) st_m[kind-5].alert_active = 1'b0;
    endcase
    check_all();
  endtask
  // Reset with fresh nonvolatile defaults; the first edge after release loads them
  task automatic do_reset();
    @(negedge clk_sys);
    rst_n = 1'b0;
    nv_a  = rand_lim();
    nv_b  = rand_lim();
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    {res_m, cfg_m} = '0;
    st_m  = '{default: '0};
    lim_m = '{nv_a, nv_b};
    check_all();
  endtask
  task automatic random_op();
    logic [31:0] r;
    int          k;
    r = $random(seed);
    k = int'(r[2:0]) % 7;
    case (k)
      0: op(0, r[20] ? lim_m[r[21]][(r[22] ? 18 : 2) +: 14] : r[31:18]);
      1, 2: op(k, rand_lim());
      3: op(3, cfg_byte(r[15:8]));
      default: op(k, r);
    endcase
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence: four mode mixes at random, then the disabled-alert corner
  initial begin
    rst_n = 1'b0;
    {nv_a, nv_b} = '0;
    for (int p = 0; p < 5; p++) begin
      do_reset();
      modes = p[1:0];
      op(3, cfg_byte(8'($random(seed))));
      if (p == 4) begin
        op(1, {16'h7FFC, 16'h8000});
        op(2, {16'h7FFC, 16'h8000});
        for (int i = 0; i < 8; i++) begin
          op(3, cfg_byte({i[1], 3'b000, i[2], 3'b000}));
          op(0, i[0] ? 14'h1FFF : 14'h2000);
        end
      end else begin
        for (int i = 0; i < 80; i++) random_op();
      end
    end
    // Bit period bounds in 100 MHz cycles for the slowest and fastest host baud
    chk_val("bit_cyc_min", 32'd866, `TLA_BIT_CYC_MIN);
    chk_val("bit_cyc_max", 32'd20833, `TLA_BIT_CYC_MAX);
    close_out();
  end
  // Whole run needs under 10 us; a hang is cut off well after that
  initial begin
    #50000;
    err_count++;
    close_out();
  end
endmodule
